//--- hw/bcep_pkg.sv
/*
 * Constants shared by the bridge clock-gating, error-cause and power-management register slice.
 * Assumes an APB register bus with 32-bit data. Each printed index takes one word,
 * so its byte address is four times the index. Assumes one 40 MHz system clock.
 */
// Contract
// - bits 13..8 stop upper clocks, high
// - two-bit fields; code 11 stops, high
// - bits 15..14 read zero, ignore writes
// - clock gating register resets to zero
// - bit 6 records delayed read time-out
// - bit 5 records delayed write time-out
// - bit 4 records posted write master abort
// - bit 3 records posted write target abort
// - bit 2 records posted write time-out
// - bit 1 records posted write parity error
// - cause bits 7, 0 zero; reset zero
// - capability identifier always reads 01h
// - next pointer E4h hot-swap, else 00h
// - per-cause mask bit suppresses system error
package bcep_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;

   // register indices; byte address is index times four
   localparam logic [7:0] IDX_CLK_GATE = 8'h68;
   localparam logic [7:0] IDX_ERR_CAUSE = 8'h6A;
   localparam logic [7:0] IDX_ERR_MASK = 8'h6C;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h70;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h71;
   localparam logic [7:0] IDX_CAP_ID = 8'hDC;
   localparam logic [7:0] IDX_NEXT_PTR = 8'hDD;
   localparam logic [ADDR_W-1:0] ADDR_CLK_GATE = {2'h0, IDX_CLK_GATE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_ERR_CAUSE = {2'h0, IDX_ERR_CAUSE, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_ERR_MASK = {2'h0, IDX_ERR_MASK, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'h0, IDX_IRQ_STATUS, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_CAP_ID = {2'h0, IDX_CAP_ID, 2'h0};
   localparam logic [ADDR_W-1:0] ADDR_NEXT_PTR = {2'h0, IDX_NEXT_PTR, 2'h0};

   // reset values and writable bits
   localparam logic [15:0] CLK_GATE_RST = 16'h0000;
   localparam logic [15:0] CLK_GATE_WMASK = 16'h3FFF;
   localparam logic [7:0] ERR_CAUSE_RST = 8'h00;
   localparam logic [7:0] CAUSE_WMASK = 8'h7E;
   localparam logic [7:0] ERR_MASK_RST = 8'h00;
   localparam logic [7:0] IRQ_STATUS_RST = 8'h00;
   localparam logic [7:0] IRQ_MASK_RST = 8'h00;
   localparam logic [7:0] CAP_ID_VAL = 8'h01;
   localparam logic [7:0] NEXT_PTR_HOT_SWAP = 8'hE4;
   localparam logic [7:0] NEXT_PTR_OTHER = 8'h00;

   // secondary clock fields
   localparam int NUM_SEC_CLK = 10;
   localparam int NUM_NARROW = 4;
   localparam int UPPER_GATE_LSB = 8;
   localparam logic [1:0] GATE_STOP_CODE = 2'h3;

   // error cause bit positions
   localparam int BIT_READ_TIMEOUT = 6;
   localparam int BIT_WRITE_TIMEOUT = 5;
   localparam int BIT_POSTED_MASTER_ABORT = 4;
   localparam int BIT_POSTED_TARGET_ABORT = 3;
   localparam int BIT_POSTED_TIMEOUT = 2;
   localparam int BIT_POSTED_PARITY = 1;

   // secondary clock rate derived from the system clock
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int SEC_CLK_HZ = 10_000_000;
   localparam int SEC_HALF_CYC = SYS_CLK_HZ / (2 * SEC_CLK_HZ);
   localparam int DIV_W = 4;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_HALF_CYC - 1);
endpackage

//--- hw/bcep_clk_gate.sv
/*
 * One secondary clock output: toggles on each divider tick, held high while stopped.
 * Assumes i_tick is a one-cycle enable from a free divider in the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module bcep_clk_gate (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_tick,
   input wire logic i_stop,
   output logic o_clk_out
);
   typedef struct packed {
      logic clk_out;
   } bcep_gate_state_t;

   bcep_gate_state_t s_r;
   bcep_gate_state_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (i_stop) begin
         s_nxt.clk_out = 1'b1;
      end else if (i_tick) begin
         s_nxt.clk_out = ~s_r.clk_out;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_r.clk_out <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign o_clk_out = s_r.clk_out;
endmodule
`default_nettype wire

//--- hw/bcep_regs.sv
/*
 * Register slice of the bridge: secondary clock gating, sticky error cause flags with
 * their masks, system error pulse, interrupt status and mask, power-management capability
 * identifier and next pointer. Served over APB with zero wait states.
 * Assumes error events arrive as one-cycle pulses synchronous to i_clk and that the
 * hot-swap strap is stable while i_srst is high.
 */
`timescale 1ns/1ps
`default_nettype none
module bcep_regs
   import bcep_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [bcep_pkg::ADDR_W-1:0] i_paddr,
   input wire logic [bcep_pkg::DATA_W-1:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic [bcep_pkg::DATA_W-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_hot_swap_mode,
   input wire logic i_evt_read_timeout,
   input wire logic i_evt_write_timeout,
   input wire logic i_evt_posted_master_abort,
   input wire logic i_evt_posted_target_abort,
   input wire logic i_evt_posted_timeout,
   input wire logic i_evt_posted_parity,
   output logic o_primary_system_error,
   output logic o_irq,
   output logic o_sec_clock_out_0,
   output logic o_sec_clock_out_1,
   output logic o_sec_clock_out_2,
   output logic o_sec_clock_out_3,
   output logic o_sec_clock_out_4,
   output logic o_sec_clock_out_5,
   output logic o_sec_clock_out_6,
   output logic o_sec_clock_out_7,
   output logic o_sec_clock_out_8,
   output logic o_sec_clock_out_9
);
   import bcep_pkg::*;

   typedef struct packed {
      logic [15:0] clk_gate;
      logic [7:0] err_cause;
      logic [7:0] err_mask;
      logic [7:0] irq_status;
      logic [7:0] irq_mask;
      logic hot_swap;
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
      logic serr;
      logic irq;
      logic [DIV_W-1:0] div;
      logic tick;
   } bcep_state_t;

   bcep_state_t s_r;
   bcep_state_t s_nxt;

   logic [7:0] event_vec;
   logic [7:0] cause_set;
   logic setup;
   logic access_wr;
   logic mapped;
   logic wr_clk_gate;
   logic wr_err_cause;
   logic [DATA_W-1:0] rd_val;
   logic [NUM_SEC_CLK-1:0] gate_stop;
   logic [NUM_SEC_CLK-1:0] sec_clk;

   always_comb begin
      event_vec = 8'h00;
      event_vec[BIT_READ_TIMEOUT] = i_evt_read_timeout;
      event_vec[BIT_WRITE_TIMEOUT] = i_evt_write_timeout;
      event_vec[BIT_POSTED_MASTER_ABORT] = i_evt_posted_master_abort;
      event_vec[BIT_POSTED_TARGET_ABORT] = i_evt_posted_target_abort;
      event_vec[BIT_POSTED_TIMEOUT] = i_evt_posted_timeout;
      event_vec[BIT_POSTED_PARITY] = i_evt_posted_parity;
   end

   // an event raises the system error and is recorded only while its mask bit is clear
   assign cause_set = event_vec & ~s_r.err_mask & CAUSE_WMASK;

   assign setup = i_psel & ~i_penable;
   assign access_wr = i_psel & i_penable & s_r.pready & ~s_r.pslverr & i_pwrite;
   assign wr_clk_gate = access_wr & (i_paddr == ADDR_CLK_GATE);
   assign wr_err_cause = access_wr & (i_paddr == ADDR_ERR_CAUSE) & i_pstrb[0];

   always_comb begin
      mapped = 1'b1;
      rd_val = '0;
      case (i_paddr)
         ADDR_CLK_GATE: rd_val = {16'h0000, s_r.clk_gate & CLK_GATE_WMASK};
         ADDR_ERR_CAUSE: rd_val = {24'h000000, s_r.err_cause & CAUSE_WMASK};
         ADDR_ERR_MASK: rd_val = {24'h000000, s_r.err_mask};
         ADDR_IRQ_STATUS: rd_val = {24'h000000, s_r.irq_status};
         ADDR_IRQ_MASK: rd_val = {24'h000000, s_r.irq_mask};
         ADDR_CAP_ID: rd_val = {24'h000000, CAP_ID_VAL};
         ADDR_NEXT_PTR: begin
            rd_val = {24'h000000, s_r.hot_swap ? NEXT_PTR_HOT_SWAP : NEXT_PTR_OTHER};
         end
         default: mapped = 1'b0;
      endcase
   end

   always_comb begin
      s_nxt = s_r;
      // zero-wait slave: answer is registered in the setup cycle
      s_nxt.pready = setup;
      s_nxt.pslverr = setup & ~mapped;
      s_nxt.prdata = (setup & ~i_pwrite & mapped) ? rd_val : '0;

      if (wr_clk_gate) begin
         if (i_pstrb[0]) begin
            s_nxt.clk_gate[7:0] = i_pwdata[7:0];
         end
         if (i_pstrb[1]) begin
            s_nxt.clk_gate[15:8] = i_pwdata[15:8] & CLK_GATE_WMASK[15:8];
         end
      end

      // software may clear or set; a hardware set in the same cycle wins
      if (wr_err_cause) begin
         s_nxt.err_cause = i_pwdata[7:0] & CAUSE_WMASK;
      end
      s_nxt.err_cause = s_nxt.err_cause | cause_set;

      if (access_wr & (i_paddr == ADDR_ERR_MASK) & i_pstrb[0]) begin
         s_nxt.err_mask = i_pwdata[7:0] & CAUSE_WMASK;
      end
      if (access_wr & (i_paddr == ADDR_IRQ_MASK) & i_pstrb[0]) begin
         s_nxt.irq_mask = i_pwdata[7:0] & CAUSE_WMASK;
      end
      if (access_wr & (i_paddr == ADDR_IRQ_STATUS) & i_pstrb[0]) begin
         s_nxt.irq_status = s_r.irq_status & ~i_pwdata[7:0];
      end
      s_nxt.irq_status = s_nxt.irq_status | cause_set;

      s_nxt.serr = |cause_set;
      s_nxt.irq = |(s_r.irq_status & s_r.irq_mask);

      // divider for the secondary clocks
      s_nxt.tick = (s_r.div == DIV_LAST);
      s_nxt.div = (s_r.div == DIV_LAST) ? '0 : s_r.div + DIV_W'(1);
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         s_r <= '0;
         s_r.clk_gate <= CLK_GATE_RST;
         s_r.err_cause <= ERR_CAUSE_RST;
         s_r.err_mask <= ERR_MASK_RST;
         s_r.irq_status <= IRQ_STATUS_RST;
         s_r.irq_mask <= IRQ_MASK_RST;
         // strap sampled while reset is held
         s_r.hot_swap <= i_hot_swap_mode;
      end else begin
         s_r <= s_nxt;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SEC_CLK; gi++) begin : g_sec
         if (gi < NUM_NARROW) begin : g_narrow
            assign gate_stop[gi] = (s_r.clk_gate[2*gi+1:2*gi] == GATE_STOP_CODE);
         end else begin : g_upper
            assign gate_stop[gi] = s_r.clk_gate[UPPER_GATE_LSB+gi-NUM_NARROW];
         end
         bcep_clk_gate u_gate (
            .i_clk(i_clk),
            .i_srst(i_srst),
            .i_tick(s_r.tick),
            .i_stop(gate_stop[gi]),
            .o_clk_out(sec_clk[gi])
         );
      end
   endgenerate

   assign o_prdata = s_r.prdata;
   assign o_pready = s_r.pready;
   assign o_pslverr = s_r.pslverr;
   assign o_primary_system_error = s_r.serr;
   assign o_irq = s_r.irq;
   assign o_sec_clock_out_0 = sec_clk[0];
   assign o_sec_clock_out_1 = sec_clk[1];
   assign o_sec_clock_out_2 = sec_clk[2];
   assign o_sec_clock_out_3 = sec_clk[3];
   assign o_sec_clock_out_4 = sec_clk[4];
   assign o_sec_clock_out_5 = sec_clk[5];
   assign o_sec_clock_out_6 = sec_clk[6];
   assign o_sec_clock_out_7 = sec_clk[7];
   assign o_sec_clock_out_8 = sec_clk[8];
   assign o_sec_clock_out_9 = sec_clk[9];

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   a_upper_gate_high: assert property (
      s_r.clk_gate[UPPER_GATE_LSB] |=> o_sec_clock_out_4)
      else $error("upper secondary clock not held high while stopped");

   a_narrow_gate_high: assert property (
      (s_r.clk_gate[1:0] == 2'h3) |=> o_sec_clock_out_0)
      else $error("lower secondary clock not held high for code 11");

   a_narrow_gate_runs: assert property (
      (s_r.clk_gate[1:0] == 2'h2) [*6] |-> (o_sec_clock_out_0 != $past(o_sec_clock_out_0, 2)))
      else $error("lower secondary clock stopped for a running code");

   a_gate_reserved_zero: assert property (
      s_r.clk_gate[15:14] == 2'h0)
      else $error("reserved clock gating bits became set");

   a_reset_values_zero: assert property (
      $fell(i_srst) |-> (s_r.clk_gate == 16'h0000) && (s_r.err_cause == 8'h00))
      else $error("registers not zero after reset");

   a_read_timeout_set: assert property (
      i_evt_read_timeout && !s_r.err_mask[6] |=> s_r.err_cause[6] && o_primary_system_error)
      else $error("delayed read time-out not recorded");

   a_other_causes_set: assert property (
      (event_vec[5:2] & ~s_r.err_mask[5:2]) != 4'h0
      |=> (s_r.err_cause[5:2] & $past(event_vec[5:2] & ~s_r.err_mask[5:2]))
          == $past(event_vec[5:2] & ~s_r.err_mask[5:2]))
      else $error("error cause not recorded");

   a_parity_cause_set: assert property (
      i_evt_posted_parity && !s_r.err_mask[1] |=> s_r.err_cause[1])
      else $error("posted write parity error not recorded");

   a_cause_reserved_zero: assert property (
      !s_r.err_cause[7] && !s_r.err_cause[0])
      else $error("reserved cause bits became set");

   a_cap_id_read: assert property (
      setup && !i_pwrite && (i_paddr == ADDR_CAP_ID) |=> o_pready && (o_prdata == 32'h00000001))
      else $error("capability identifier read wrong");

   a_next_ptr_read: assert property (
      setup && !i_pwrite && (i_paddr == ADDR_NEXT_PTR)
      |=> o_prdata == (s_r.hot_swap ? 32'h000000E4 : 32'h00000000))
      else $error("next capability pointer read wrong");

   a_masked_cause_quiet: assert property (
      i_evt_posted_parity && s_r.err_mask[1] && !s_r.err_cause[1] && !wr_err_cause
      && (cause_set == 8'h00) |=> !s_r.err_cause[1] && !o_primary_system_error)
      else $error("masked cause was recorded or signalled");

   a_cause_sticky: assert property (
      s_r.err_cause[1] && !wr_err_cause |=> s_r.err_cause[1])
      else $error("error cause cleared without a write");

   a_set_beats_clear: assert property (
      wr_err_cause && !i_pwdata[1] && cause_set[1] |=> s_r.err_cause[1])
      else $error("software clear beat hardware set");

   a_stopped_lines_high: assert property (
      (sec_clk & $past(gate_stop)) == $past(gate_stop))
      else $error("stopped secondary clock not high");

   a_upper_gate_last: assert property (
      s_r.clk_gate[13] |=> o_sec_clock_out_9)
      else $error("last upper secondary clock not held high");

   a_narrow_gate_last: assert property (
      (s_r.clk_gate[7:6] == 2'h3) |=> o_sec_clock_out_3)
      else $error("last lower secondary clock not held high");

   a_narrow_code_one: assert property (
      (s_r.clk_gate[3:2] == 2'h1) [*6] |-> (o_sec_clock_out_1 != $past(o_sec_clock_out_1, 2)))
      else $error("lower secondary clock stopped for code 01");

   a_gate_read_upper: assert property (
      setup && !i_pwrite && (i_paddr == ADDR_CLK_GATE) |=> (o_prdata[31:14] == 18'h00000))
      else $error("reserved clock gating bits read nonzero");

   a_reset_clocks_high: assert property (
      $fell(i_srst) |-> (sec_clk == 10'h3FF))
      else $error("secondary clocks not high after reset");

   a_reset_masks_zero: assert property (
      $fell(i_srst) |-> (s_r.err_mask == 8'h00) && !o_primary_system_error)
      else $error("mask or system error not clear after reset");

   a_write_timeout_set: assert property (
      i_evt_write_timeout && !s_r.err_mask[5] |=> s_r.err_cause[5])
      else $error("delayed write time-out not recorded");

   a_master_abort_set: assert property (
      i_evt_posted_master_abort && !s_r.err_mask[4] |=> s_r.err_cause[4])
      else $error("posted write master abort not recorded");

   a_target_abort_set: assert property (
      i_evt_posted_target_abort && !s_r.err_mask[3] |=> s_r.err_cause[3])
      else $error("posted write target abort not recorded");

   a_posted_timeout_set: assert property (
      i_evt_posted_timeout && !s_r.err_mask[2] |=> s_r.err_cause[2])
      else $error("posted write time-out not recorded");

   a_cause_read_zero: assert property (
      setup && !i_pwrite && (i_paddr == ADDR_ERR_CAUSE) |=> !o_prdata[7] && !o_prdata[0])
      else $error("reserved cause bits read nonzero");

   a_cap_id_error: assert property (
      setup && (i_paddr == ADDR_CAP_ID) |=> !o_pslverr)
      else $error("capability identifier access flagged as error");

   a_next_ptr_error: assert property (
      setup && (i_paddr == ADDR_NEXT_PTR) |=> !o_pslverr)
      else $error("next pointer access flagged as error");

   a_serr_unmasked: assert property (
      (cause_set != 8'h00) |=> o_primary_system_error)
      else $error("unmasked cause did not raise system error");

   a_serr_quiet: assert property (
      (cause_set == 8'h00) |=> !o_primary_system_error)
      else $error("system error raised without an unmasked cause");

   a_cause_hold_all: assert property (
      !wr_err_cause && (cause_set == 8'h00) |=> (s_r.err_cause == $past(s_r.err_cause)))
      else $error("error cause changed without write or event");

   a_ready_after_setup: assert property (
      setup |=> o_pready)
      else $error("ready missing after setup");

   a_ready_one_cycle: assert property (
      o_pready |=> !o_pready)
      else $error("ready stood longer than one cycle");

   a_idle_data_zero: assert property (
      !o_pready |-> (o_prdata == 32'h00000000))
      else $error("read data nonzero outside access");

   a_slverr_with_ready: assert property (
      o_pslverr |-> o_pready)
      else $error("error flag without ready");

   c_read_access: cover property (setup && !i_pwrite ##1 o_pready);
   c_clock_stopped: cover property ((s_r.clk_gate[7:6] == 2'h3) ##1 o_sec_clock_out_3 [*4]);
   c_irq_raised: cover property (o_primary_system_error ##[1:3] o_irq);
   c_set_and_clear: cover property (wr_err_cause && (cause_set != 8'h00));
   c_strap_pointer: cover property (s_r.hot_swap && setup && (i_paddr == ADDR_NEXT_PTR));
endmodule
`default_nettype wire

//--- test/bcep_evt_src.sv
/*
 * Stand-in for the forwarding logic that detects bridge errors.
 * Assumes the bench sets i_cause for one cycle; each set bit becomes one event pulse.
 */
`timescale 1ns/1ps
`default_nettype none
module bcep_evt_src (
   input wire logic i_clk,
   input wire logic [6:1] i_cause,
   output logic [6:1] o_evt
);
   always_ff @(posedge i_clk) begin
      o_evt <= i_cause;
   end
endmodule
`default_nettype wire

//--- test/tb_top.sv
/*
 * Self-checking bench for the bridge register slice.
 * Assumes bcep_pkg and an APB slave that answers in the access cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import bcep_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0;
   logic [DATA_W-1:0] prdata;
   logic pready;
   logic pslverr;
   logic strap = 1'b0;
   logic [3:0] strb = 4'hF;
   logic [6:1] cause = '0;
   logic [6:1] evt;
   logic serr;
   logic irq;
   logic [9:0] sck;
   logic [31:0] rd;
   logic er;
   int n_mismatch = 0;
   int comparisons = 0;

   always #12.5 clk = ~clk;

   bcep_evt_src bcep_evt_src_i (.i_clk(clk), .i_cause(cause), .o_evt(evt));

   bcep_regs bcep_regs_i (
      .i_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_hot_swap_mode(strap),
      .i_evt_read_timeout(evt[6]), .i_evt_write_timeout(evt[5]),
      .i_evt_posted_master_abort(evt[4]), .i_evt_posted_target_abort(evt[3]),
      .i_evt_posted_timeout(evt[2]), .i_evt_posted_parity(evt[1]),
      .o_primary_system_error(serr), .o_irq(irq),
      .o_sec_clock_out_0(sck[0]), .o_sec_clock_out_1(sck[1]), .o_sec_clock_out_2(sck[2]),
      .o_sec_clock_out_3(sck[3]), .o_sec_clock_out_4(sck[4]), .o_sec_clock_out_5(sck[5]),
      .o_sec_clock_out_6(sck[6]), .o_sec_clock_out_7(sck[7]), .o_sec_clock_out_8(sck[8]),
      .o_sec_clock_out_9(sck[9])
   );

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one transfer; entered just after a rising edge
   task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      chk(32'(pready), 32'h1);
      psel <= 1'b0;
      pen <= 1'b0;
      // one idle edge so the next call never reassigns psel in this time step
      @(posedge clk);
   endtask

   function automatic logic [9:0] stop_of(input logic [15:0] g);
      logic [9:0] s;
      for (int i = 0; i < 4; i++)
         s[i] = &g[2*i +: 2];
      for (int i = 4; i < 10; i++)
         s[i] = g[i+4];
      return s;
   endfunction

   // stopped lines must stay high, running lines must be seen low
   task automatic clk_chk(input logic [9:0] stopped);
      logic [9:0] lo;
      logic [9:0] hi;
      lo = '0;
      hi = '0;
      repeat (4) @(posedge clk);
      repeat (8) begin
         @(negedge clk);
         lo |= ~sck;
         hi |= sck;
      end
      chk({22'h0, lo}, {22'h0, ~stopped});
      chk({22'h0, hi}, 32'h3FF);
      @(posedge clk);
   endtask

   // pulse causes once and count system error cycles
   task automatic fire(input logic [6:1] m, output int n);
      cause <= m;
      @(posedge clk);
      cause <= '0;
      n = 0;
      repeat (5) begin
         @(negedge clk);
         if (serr === 1'b1)
            n++;
      end
      @(posedge clk);
   endtask

   task automatic t_reset;
      apb(1'b0, ADDR_CLK_GATE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, ADDR_CAP_ID, 32'hFF);
      apb(1'b0, ADDR_CAP_ID, 32'h0);
      chk(rd, 32'h01);
      apb(1'b0, ADDR_NEXT_PTR, 32'h0);
      chk(rd, 32'h00);
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      clk_chk(10'h000);
      $display("test reset done");
   endtask

   task automatic t_gate;
      logic [15:0] g;
      for (int c = 0; c < 4; c++) begin
         g = 16'hC000 | (c[0] ? 16'h2A00 : 16'h1500) | {8'h00, {4{c[1:0]}}};
         apb(1'b1, ADDR_CLK_GATE, {16'h0, g});
         apb(1'b0, ADDR_CLK_GATE, 32'h0);
         chk(rd, {16'h0, g & 16'h3FFF});
         clk_chk(stop_of(g));
      end
      strb <= 4'h2;
      apb(1'b1, ADDR_CLK_GATE, 32'h0);
      strb <= 4'hF;
      apb(1'b0, ADDR_CLK_GATE, 32'h0);
      chk(rd, 32'h00FF);
      apb(1'b1, ADDR_CLK_GATE, 32'h0);
      clk_chk(10'h000);
      $display("test clock gate done");
   endtask

   task automatic t_events;
      int n;
      apb(1'b1, ADDR_IRQ_MASK, 32'h7E);
      for (int b = 1; b < 7; b++) begin
         fire(6'(1 << (b - 1)), n);
         chk(32'(n), 32'h1);
         chk({31'h0, irq}, 32'h1);
         apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
         chk(rd, 32'(1 << b));
         apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
         chk(rd, 32'(1 << b));
         apb(1'b1, ADDR_ERR_CAUSE, 32'h0);
         apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
         chk(rd, 32'h0);
         apb(1'b1, ADDR_IRQ_STATUS, 32'h7E);
         repeat (3) @(posedge clk);
         chk({31'h0, irq}, 32'h0);
      end
      apb(1'b1, ADDR_ERR_CAUSE, 32'hFF);
      apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
      chk(rd, 32'h7E);
      apb(1'b1, ADDR_ERR_CAUSE, 32'h0);
      apb(1'b1, ADDR_ERR_MASK, 32'h7E);
      fire(6'h3F, n);
      chk(32'(n), 32'h0);
      apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, ADDR_ERR_MASK, 32'h0);
      $display("test events done");
   endtask

   // event lands in the very access cycle of a clearing write
   task automatic t_set_wins;
      fork
         apb(1'b1, ADDR_ERR_CAUSE, 32'h0);
         begin
            cause <= 6'h01;
            @(posedge clk);
            cause <= 6'h00;
         end
      join
      apb(1'b0, ADDR_ERR_CAUSE, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, ADDR_ERR_CAUSE, 32'h0);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h7E);
      $display("test set wins done");
   endtask

   task automatic t_strap;
      srst <= 1'b1;
      strap <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      apb(1'b0, ADDR_NEXT_PTR, 32'h0);
      chk(rd, 32'hE4);
      $display("test strap done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_gate();
      t_events();
      t_set_wins();
      t_strap();
      end_sim();
   end

   initial begin
      #1ms;
      n_mismatch++;
      end_sim();
   end
endmodule
`default_nettype wire
